// ---- verilog/adc_pkg.sv ----
// Purpose: Shared constants and types for the one-shot converter control block
// Assumes: Word-wide AHB-Lite access, register index times four is the byte address
// Notes: Indices, bit positions, reset values and conversion tick counts live here

package adc_pkg;

    // ************************************************************
    // Register indices (byte address is index times four)
    // ************************************************************
    localparam logic [19:0] RESULT_IDX = 20'hfff1e;
    localparam logic [19:0] MODE0_IDX = 20'hfff30;
    localparam logic [19:0] MODE1_IDX = 20'hfff32;
    localparam logic [19:0] MODE2_IDX = 20'hfff10;
    localparam logic [19:0] UPPER_IDX = 20'hfff11;
    localparam logic [19:0] LOWER_IDX = 20'hfff12;
    localparam logic [19:0] GATE_IDX = 20'hf00f0;
    localparam logic [19:0] STATUS_IDX = 20'hfff40;
    localparam logic [19:0] MASK_IDX = 20'hfff41;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int RUN_BIT = 7;
    localparam int KIND_BIT = 6;
    localparam int DIV_LSB = 3;
    localparam int LV_LSB = 1;
    localparam int COMP_BIT = 0;
    localparam int REPEAT_BIT = 5;
    localparam int RANGE_BIT = 3;
    localparam int GATE_BIT = 5;
    localparam int RES_SHIFT = 6;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] MODE0_RST = 8'h00;
    localparam logic [7:0] MODE1_RST = 8'h00;
    localparam logic [7:0] MODE2_RST = 8'h00;
    localparam logic [7:0] UPPER_RST = 8'hff;
    localparam logic [7:0] LOWER_RST = 8'h00;
    localparam logic [7:0] GATE_RST = 8'h00;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // ************************************************************
    // Timing counts in conversion clock ticks, and the last scan position
    // ************************************************************
    localparam logic [4:0] TICKS_NORMAL1 = 5'd19;
    localparam logic [4:0] TICKS_NORMAL2 = 5'd17;
    localparam logic [4:0] TICKS_OTHER = 5'd19;
    localparam logic [1:0] SCAN_LAST = 2'd3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11
    } conv_state_e;

    // System clock cycles per conversion clock tick
    function automatic logic [6:0] div_ratio(input logic [2:0] sel);
        case (sel)
            3'h0: div_ratio = 7'd64;
            3'h1: div_ratio = 7'd32;
            3'h2: div_ratio = 7'd16;
            3'h3: div_ratio = 7'd8;
            3'h4: div_ratio = 7'd6;
            3'h5: div_ratio = 7'd5;
            3'h6: div_ratio = 7'd4;
            default: div_ratio = 7'd2;
        endcase
    endfunction

    // Conversion clock ticks per conversion
    function automatic logic [4:0] conv_ticks(input logic [1:0] sel);
        case (sel)
            2'h0: conv_ticks = TICKS_NORMAL1;
            2'h1: conv_ticks = TICKS_NORMAL2;
            default: conv_ticks = TICKS_OTHER;
        endcase
    endfunction

endpackage

// ---- verilog/conv_timer.sv ----
// Purpose: Divides the system clock to the conversion clock and times one conversion
// Assumes: run stays high for the whole conversion
// Notes: done is a one-cycle pulse one cycle after the last tick

`timescale 1ns/100ps

module conv_timer import adc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [2:0] div_sel,
    input wire logic [1:0] time_sel,
    output logic done
);

    logic [6:0] pre;
    logic [4:0] ticks;

    // Tick decode
    wire fad_tick = (pre == div_ratio(div_sel) - 7'd1);
    wire last_tick = fad_tick && (ticks == conv_ticks(time_sel) - 5'd1);

    // Counters rest at zero while stopped so each start is a clean one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre <= 7'd0;
            ticks <= 5'd0;
            done <= 1'b0;
        end else if (!run) begin
            pre <= 7'd0;
            ticks <= 5'd0;
            done <= 1'b0;
        end else begin
            pre <= fad_tick ? 7'd0 : pre + 7'd1;
            if (fad_tick) begin
                ticks <= last_tick ? 5'd0 : ticks + 5'd1;
            end
            done <= last_tick;
        end
    end

endmodule

// ---- verilog/adc_ctrl.sv ----
// Purpose: Software-triggered converter control with result register and limit check
// Assumes: analog_sample holds the digitised input of the selected channel
// Notes: AHB-Lite slave, one wait state per transfer, word access only
//
// The AHB-Lite slave port was chosen for this implementation.

`timescale 1ns/100ps

module adc_ctrl import adc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [9:0] analog_sample,
    output logic [1:0] scan_channel,
    output logic comparator_on,
    output logic irq
);

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic pend;
    logic pend_write;
    logic pend_map;
    logic [19:0] pend_idx;

    // Address phase decode; sub-word sizes and misaligned addresses decode as unmapped
    wire take = hsel && hready && htrans[1];
    wire aligned = (haddr[31:22] == 10'h000) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);

    // One wait state so reads see writes that finish just before them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= 1'b0;
            pend_write <= 1'b0;
            pend_map <= 1'b0;
            pend_idx <= 20'h00000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (take) begin
            pend <= 1'b1;
            pend_write <= hwrite;
            pend_map <= aligned;
            pend_idx <= haddr[21:2];
            hreadyout <= 1'b0;
        end else begin
            pend <= 1'b0;
            hreadyout <= 1'b1;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic [7:0] upper_limit_reg;
    logic [7:0] lower_limit_reg;
    logic [7:0] clock_gate;
    logic [15:0] conv_result_reg;
    logic irq_status;
    logic irq_mask;
    conv_state_e state;
    conv_state_e next_state;
    logic tdone;

    wire gate_on = clock_gate[GATE_BIT];
    wire wr_fire = pend && pend_write && pend_map;
    wire rd_fire = pend && !pend_write;
    wire wr_conv = wr_fire && gate_on;
    wire wr_mode0 = wr_conv && (pend_idx == MODE0_IDX);
    wire wr_mode1 = wr_conv && (pend_idx == MODE1_IDX);
    wire wr_mode2 = wr_conv && (pend_idx == MODE2_IDX);
    wire wr_upper = wr_conv && (pend_idx == UPPER_IDX);
    wire wr_lower = wr_conv && (pend_idx == LOWER_IDX);
    wire wr_gate = wr_fire && (pend_idx == GATE_IDX);
    wire wr_status = wr_fire && (pend_idx == STATUS_IDX);
    wire wr_mask = wr_fire && (pend_idx == MASK_IDX);

    // Mode field decode
    wire run = mode0[RUN_BIT];
    wire scan_mode = mode0[KIND_BIT];
    wire comp_en = mode0[COMP_BIT] && gate_on;
    wire one_shot = mode1[REPEAT_BIT];
    wire range_out = mode2[RANGE_BIT];
    wire start_ok = run && comp_en;
    wire scan_end = !scan_mode || (scan_channel == SCAN_LAST);

    // Window check on the upper eight result bits
    wire [7:0] res_hi = conv_result_reg[15:8];
    wire in_range = (lower_limit_reg <= res_hi) && (res_hi <= upper_limit_reg);
    wire window_ok = range_out ? !in_range : in_range;

    // Conversion end and run clearing
    wire conv_end = (state == ST_CONV) && tdone;
    wire finish = (state == ST_DONE) && one_shot && scan_end;
    wire stop_run = finish || !comp_en;
    wire done_evt = (state == ST_DONE) && window_ok;

    // Read data; converter registers read zero while its clock is gated
    wire conv_rd = gate_on;
    wire [7:0] rd_byte =
        (pend_idx == MODE0_IDX && conv_rd) ? mode0 :
        (pend_idx == MODE1_IDX && conv_rd) ? mode1 :
        (pend_idx == MODE2_IDX && conv_rd) ? mode2 :
        (pend_idx == UPPER_IDX && conv_rd) ? upper_limit_reg :
        (pend_idx == LOWER_IDX && conv_rd) ? lower_limit_reg :
        (pend_idx == GATE_IDX) ? clock_gate :
        (pend_idx == STATUS_IDX) ? {7'h00, irq_status} :
        (pend_idx == MASK_IDX) ? {7'h00, irq_mask} : 8'h00;
    wire [31:0] rd_value = !pend_map ? 32'h00000000 :
        (pend_idx == RESULT_IDX && conv_rd) ? {16'h0000, conv_result_reg} :
        {24'h000000, rd_byte};

    // Read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_fire) begin
            hrdata <= rd_value;
        end
    end

    // Gate register is always writable; it unlocks the mode and limit registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_gate <= GATE_RST;
        end else if (wr_gate) begin
            clock_gate <= hwdata[7:0];
        end
    end

    // Mode zero; a software write wins over the hardware run clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode0 <= MODE0_RST;
        end else if (wr_mode0) begin
            mode0 <= hwdata[7:0];
        end else if (stop_run) begin
            mode0[RUN_BIT] <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode1 <= MODE1_RST;
            mode2 <= MODE2_RST;
            upper_limit_reg <= UPPER_RST;
            lower_limit_reg <= LOWER_RST;
        end else begin
            if (wr_mode1) mode1 <= hwdata[7:0];
            if (wr_mode2) mode2 <= hwdata[7:0];
            if (wr_upper) upper_limit_reg <= hwdata[7:0];
            if (wr_lower) lower_limit_reg <= hwdata[7:0];
        end
    end

    // Result has no write path at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_result_reg <= RESULT_RST;
        end else if (conv_end) begin
            conv_result_reg <= {analog_sample, 6'h00};
        end
    end

    // ************************************************************
    // Conversion sequencer
    // ************************************************************

    // Dropping run, comparator or clock gate aborts at once
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_ok) next_state = ST_CONV;
            end
            ST_CONV: begin
                if (!start_ok) next_state = ST_IDLE;
                else if (tdone) next_state = ST_DONE;
            end
            ST_DONE: begin
                if (start_ok && !finish) next_state = ST_CONV;
                else next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State and scan position
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            scan_channel <= 2'd0;
        end else begin
            state <= next_state;
            if (!scan_mode || state == ST_IDLE) begin
                scan_channel <= 2'd0;
            end else if (state == ST_DONE) begin
                scan_channel <= scan_channel + 2'd1;
            end
        end
    end

    // Conversion timing; stops with the gated converter clock
    conv_timer u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(state == ST_CONV),
        .div_sel(mode0[DIV_LSB +: 3]),
        .time_sel(mode0[LV_LSB +: 2]),
        .done(tdone)
    );

    // ************************************************************
    // Interrupt
    // ************************************************************

    // Sticky end flag; a new event beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 1'b0;
            irq_mask <= 1'b0;
            irq <= 1'b0;
            comparator_on <= 1'b0;
        end else begin
            irq_status <= (irq_status && !(wr_status && hwdata[0])) || done_evt;
            if (wr_mask) irq_mask <= hwdata[0];
            irq <= irq_status && irq_mask;
            comparator_on <= comp_en;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_LOAD_RESULT:
        assert property (conv_end |=> conv_result_reg == {$past(analog_sample), 6'h00})
        else $error("Result not loaded at conversion end");
    AST_EVENT_SET:
        assert property ((state == ST_DONE) && window_ok |=> irq_status)
        else $error("End event lost");
    AST_ONE_SHOT_STOP:
        assert property (finish && !wr_mode0 |=> !run ##1 state == ST_IDLE)
        else $error("One-shot did not stop");
    AST_START:
        assert property ((state == ST_IDLE) && start_ok |=> state == ST_CONV)
        else $error("Conversion did not start");
    AST_LEFT_JUST:
        assert property (conv_result_reg[5:0] == 6'h00)
        else $error("Result not left-justified");
    AST_GATE_BLOCK:
        assert property (wr_fire && !gate_on && pend_idx == MODE2_IDX |=> $stable(mode2))
        else $error("Write passed closed gate");
    AST_WINDOW:
        assert property ($rose(irq_status) |-> $past(state == ST_DONE && window_ok))
        else $error("Event outside window setting");
    // Software clearing run lands one edge before the sequencer leaves conversion
    AST_RUN_READ:
        assert property ((state == ST_CONV) |-> $past(run))
        else $error("Converting with run bit clear");
    AST_COMP_OFF:
        assert property (!comp_en |=> state == ST_IDLE && !comparator_on)
        else $error("Converter ran with comparator off");
    AST_RESULT_HOLD:
        assert property (!conv_end |=> $stable(conv_result_reg))
        else $error("Result changed without conversion");
    AST_SCAN_COUNT:
        assert property (!scan_mode |=> scan_channel == 2'd0 || scan_mode)
        else $error("Scan position moved in select mode");
    AST_REPEAT:
        assert property ((state == ST_DONE) && !one_shot && start_ok |=> state == ST_CONV)
        else $error("Continuous mode did not restart");

endmodule

// ---- dv/adc_one_shot_select_control_bench.sv ----
// Purpose: Self-checking bench for the one-shot converter control block
// Assumes: One AHB-Lite master, bus hready fed back from hreadyout
// Notes: Fast divider settings keep most conversions short

`timescale 1ns/100ps

module adc_one_shot_select_control_bench import adc_pkg::*; ;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic hwrite;
    logic hreadyout;
    logic hresp;
    logic comparator_on;
    logic irq;
    logic [1:0] htrans;
    logic [1:0] scan_channel;
    logic [2:0] hsize;
    logic [9:0] analog_sample;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    adc_ctrl adc_ctrl_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hreadyout),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .analog_sample(analog_sample),
        .scan_channel(scan_channel),
        .comparator_on(comparator_on),
        .irq(irq)
    );

    // ************************************************************
    // Clock, timeout and shared tasks
    // ************************************************************
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // Cut a hang short; whole run needs a few thousand cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    // Address phase held until hready is sampled high
    task automatic bus_addr(input logic [19:0] idx, input logic wr);
        hsel <= 1'b1;
        haddr <= {10'h000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
    endtask

    task automatic bus_write(input logic [19:0] idx, input logic [31:0] d);
        bus_addr(idx, 1'b1);
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic bus_read(input logic [19:0] idx, output logic [31:0] d);
        bus_addr(idx, 1'b0);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    task automatic expect_reg(input string what, input logic [19:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus_read(idx, d);
        chk(what, exp, d);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset values; gate closed hides registers, unmapped reads zero
    task automatic t_reset();
        expect_reg("gate", GATE_IDX, 32'h0);
        expect_reg("mode0 gated", MODE0_IDX, 32'h0);
        bus_write(GATE_IDX, 32'h20);
        expect_reg("gate on", GATE_IDX, 32'h20);
        expect_reg("upper", UPPER_IDX, 32'hff);
        expect_reg("lower", LOWER_IDX, 32'h0);
        expect_reg("mode1", MODE1_IDX, 32'h0);
        expect_reg("mode2", MODE2_IDX, 32'h0);
        expect_reg("result", RESULT_IDX, 32'h0);
        expect_reg("status", STATUS_IDX, 32'h0);
        expect_reg("mask", MASK_IDX, 32'h0);
        bus_write(20'h00123, 32'hff);
        expect_reg("unmapped", 20'h00123, 32'h0);
        chk("hresp okay", 32'h0, {31'h0, hresp});
        chk("irq idle", 32'h0, {31'h0, irq});
    endtask

    // Writes with the gate closed are lost; comparator follows enable
    task automatic t_gate();
        bus_write(GATE_IDX, 32'h0);
        bus_write(MODE0_IDX, 32'h01);
        bus_write(MODE2_IDX, 32'h08);
        bus_write(GATE_IDX, 32'h20);
        expect_reg("mode0 blocked", MODE0_IDX, 32'h0);
        expect_reg("mode2 blocked", MODE2_IDX, 32'h0);
        chk("comparator off", 32'h0, {31'h0, comparator_on});
        bus_write(MODE0_IDX, 32'h01);
        @(posedge hclk);
        chk("comparator on", 32'h1, {31'h0, comparator_on});
        bus_write(MODE0_IDX, 32'h0);
        @(posedge hclk);
        chk("comparator stopped", 32'h0, {31'h0, comparator_on});
    endtask

    // One conversion at fclk/8, then nothing more until restarted
    task automatic t_one_shot();
        int n;
        bus_write(MODE1_IDX, 32'h20);
        bus_write(MASK_IDX, 32'h1);
        analog_sample <= 10'h2a5;
        bus_write(MODE0_IDX, 32'h99);
        expect_reg("run busy", MODE0_IDX, 32'h99);
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        chk("irq raised", 32'h1, {31'h0, irq});
        chk("conversion time", 32'h1, {31'h0, (n >= 140 && n <= 165)});
        expect_reg("result", RESULT_IDX, 32'ha940);
        expect_reg("run done", MODE0_IDX, 32'h19);
        bus_write(RESULT_IDX, 32'hffff);
        analog_sample <= 10'h01f;
        repeat (300) @(posedge hclk);
        expect_reg("result held", RESULT_IDX, 32'ha940);
        chk("select channel", 32'h0, {30'h0, scan_channel});
        bus_write(STATUS_IDX, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        expect_reg("status cleared", STATUS_IDX, 32'h0);
        // Masked event keeps the line low but still sets status
        bus_write(MASK_IDX, 32'h0);
        bus_write(MODE0_IDX, 32'hb9);
        repeat (80) @(posedge hclk);
        chk("masked irq", 32'h0, {31'h0, irq});
        expect_reg("status set", STATUS_IDX, 32'h1);
        expect_reg("new result", RESULT_IDX, 32'h07c0);
        bus_write(MASK_IDX, 32'h1);
        repeat (2) @(posedge hclk);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        bus_write(STATUS_IDX, 32'h1);
    endtask

    // Window boundaries: equal to a limit passes, one beyond fails;
    // the second pass flips to the out-of-range check
    task automatic t_window();
        logic [7:0] lvl [4] = '{8'h40, 8'h80, 8'h3f, 8'h81};
        bus_write(UPPER_IDX, 32'h80);
        bus_write(LOWER_IDX, 32'h40);
        for (int i = 0; i < 8; i++) begin
            if (i == 4) begin
                bus_write(MODE2_IDX, 32'h08);
            end
            analog_sample <= {lvl[i % 4], 2'b00};
            bus_write(MODE0_IDX, 32'hb9);
            repeat (80) @(posedge hclk);
            expect_reg("window status", STATUS_IDX, {31'h0, ((i % 4) < 2) != (i >= 4)});
            bus_write(STATUS_IDX, 32'h1);
        end
        bus_write(MODE2_IDX, 32'h0);
        bus_write(UPPER_IDX, 32'hff);
        bus_write(LOWER_IDX, 32'h0);
    endtask

    // Scan kind walks four positions, then one-shot stops it
    task automatic t_scan();
        logic seen;
        seen = 1'b0;
        bus_write(MODE0_IDX, 32'hf9);
        repeat (300) begin
            @(posedge hclk);
            if (scan_channel === 2'd3) seen = 1'b1;
        end
        chk("scan reached last", 32'h1, {31'h0, seen});
        expect_reg("scan stopped", MODE0_IDX, 32'h79);
        bus_write(STATUS_IDX, 32'h1);
    endtask

    // Sequential mode keeps run set until software stops it
    task automatic t_continuous();
        bus_write(MODE1_IDX, 32'h0);
        bus_write(MODE0_IDX, 32'hb9);
        repeat (200) @(posedge hclk);
        expect_reg("still running", MODE0_IDX, 32'hb9);
        bus_write(MODE0_IDX, 32'h0);
        expect_reg("stopped", MODE0_IDX, 32'h0);
        bus_write(STATUS_IDX, 32'h1);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        analog_sample = 10'h000;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_gate();
        t_one_shot();
        t_window();
        t_scan();
        t_continuous();
        report_and_stop();
    end

endmodule
